// File: design/remote_safety_regs.svh
// timing constants and counts of the transmitter sequencer
`ifndef REMOTE_SAFETY_REGS_SVH
`define REMOTE_SAFETY_REGS_SVH
`define CLK_HZ           20000000
`define LEARN_HOLD_S     10
`define LEARN_HOLD_CYC   (`LEARN_HOLD_S * `CLK_HZ)
`define DAMAGE_RED_S     2
`define DAMAGE_RED_CYC   (`DAMAGE_RED_S * `CLK_HZ)
`define FAST_HALF_MS     100
`define FAST_HALF_CYC    (`FAST_HALF_MS * (`CLK_HZ / 1000))
`define SLOW_HALF_MS     500
`define SLOW_HALF_CYC    (`SLOW_HALF_MS * (`CLK_HZ / 1000))
`define PULSE_HALF_MS    250
`define PULSE_HALF_CYC   (`PULSE_HALF_MS * (`CLK_HZ / 1000))
`define ERR_STOP_PULSES  3'h1
`define ERR_ONOFF_PULSES 3'h2
`define ERR_BATT_PULSES  3'h3
`define ERR_JOY_PULSES   3'h4
`endif

// File: design/remote_safety_pkg.sv
// types shared by the transmitter sequencer modules
package remote_safety_pkg;
  typedef enum logic [1:0] {
    LED_OFF,
    LED_GREEN,
    LED_RED
  } led_color_t;

  typedef struct packed {
    logic stop_pressed;
    logic key_pos1;
    logic start;
    logic onoff_active;
    logic joystick_off_zero;
    logic battery_low;
    logic damage;
    logic receiver_present;
  } tx_inputs_t;

  typedef struct packed {
    logic link_open;
    logic system_on;
    logic stop_cmd;
    logic unintended_motion_guard;
    logic learn_code;
  } tx_commands_t;
endpackage

// File: design/flash_divider.sv
// one-cycle tick generator and square-wave toggle for a flash pattern
module flash_divider #(
  parameter int unsigned HALF_CYC = 10
) (
  input  wire logic sys_clk_i,
  input  wire logic arst_n_i,
  input  wire logic clear_i,
  output logic      tick_o,
  output logic      phase_o
);
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic        phase_reg;
  logic        phase_next;

  always_comb begin
    cnt_next   = cnt_reg + 32'h1;
    phase_next = phase_reg;
    tick_o     = 1'b0;
    if (clear_i) begin
      cnt_next   = 32'h0;
      phase_next = 1'b0;
    end else if (cnt_reg >= HALF_CYC - 1) begin
      cnt_next   = 32'h0;
      phase_next = ~phase_reg;
      tick_o     = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_reg   <= 32'h0;
      phase_reg <= 1'b0;
    end else begin
      cnt_reg   <= cnt_next;
      phase_reg <= phase_next;
    end
  end

  assign phase_o = phase_reg;
endmodule

// File: design/hold_timer.sv
// counts how long a condition has held and flags when it reaches the limit
module hold_timer #(
  parameter int unsigned LIMIT_CYC = 100
) (
  input  wire logic sys_clk_i,
  input  wire logic arst_n_i,
  input  wire logic run_i,
  output logic      done_o
);
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;

  always_comb begin
    cnt_next = cnt_reg;
    if (!run_i) begin
      cnt_next = 32'h0;
    end else if (cnt_reg < LIMIT_CYC) begin
      cnt_next = cnt_reg + 32'h1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_reg <= 32'h0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign done_o = (cnt_reg >= LIMIT_CYC);
endmodule

// File: design/remote_safety_sequencer.sv
// transmitter operating and safety sequencer with status indicator and buzzer
//
// Summary of operation
// - stop pressed, key at 1, start held ten seconds: learn code, end green blinking
// - mushroom at rest, key to 1: open link at once, green flashes fast
// - start after enabling switches system on; green flashes slowly; receiver obeys
// - pressing mushroom or key to 0 switches the transmitter off
// - mushroom while on sends stop; receiver opens stop circuit within 130 ms
// - safety command sent while system on whenever any joystick is away from zero
// - low battery while running flashes red slowly
// - at activation: one red flash for mushroom, two for on/off active
// - at activation: three red flashes for low battery, four for joystick
// - internal damage holds red steady two seconds then dark
// - buzzer sounds whenever red error or low battery indication is lit
`include "remote_safety_regs.svh"
module remote_safety_sequencer #(
  parameter int unsigned LEARN_HOLD_CYC = `LEARN_HOLD_CYC,
  parameter int unsigned DAMAGE_RED_CYC = `DAMAGE_RED_CYC,
  parameter int unsigned FAST_HALF_CYC  = `FAST_HALF_CYC,
  parameter int unsigned SLOW_HALF_CYC  = `SLOW_HALF_CYC,
  parameter int unsigned PULSE_HALF_CYC = `PULSE_HALF_CYC
) (
  input  wire logic                        sys_clk_i,
  input  wire logic                        arst_n_i,
  input  wire remote_safety_pkg::tx_inputs_t   in_i,
  output remote_safety_pkg::tx_commands_t      cmd_o,
  output remote_safety_pkg::led_color_t        led_o,
  output logic                             buzzer_o
);
  typedef enum logic [2:0] {
    ST_OFF,
    ST_LEARN,
    ST_WAIT_START,
    ST_ON,
    ST_ERROR,
    ST_DAMAGE,
    ST_LOCKED
  } seq_state_t;

  seq_state_t                       state_reg;
  seq_state_t                       state_next;
  logic [2:0]                       pulses_reg;
  logic [2:0]                       pulses_next;
  logic [2:0]                       done_reg;
  logic [2:0]                       done_next;
  logic                             key_prev_reg;
  logic                             key_prev_next;
  remote_safety_pkg::tx_commands_t  cmd_reg;
  remote_safety_pkg::tx_commands_t  cmd_next;
  remote_safety_pkg::led_color_t    led_reg;
  remote_safety_pkg::led_color_t    led_next;
  logic                             buzzer_reg;
  logic                             buzzer_next;

  logic fast_phase;
  logic slow_phase;
  logic pulse_tick;
  logic pulse_phase;
  logic learn_done;
  logic damage_done;
  logic key_rise;
  logic pulse_clear;

  assign key_rise    = in_i.key_pos1 && !key_prev_reg;
  assign pulse_clear = (state_reg != ST_ERROR);

  // error code priority when several faults are present at activation
  function automatic logic [2:0] activation_fault(input remote_safety_pkg::tx_inputs_t f);
    logic [2:0] n;
    n = 3'h0;
    if (f.joystick_off_zero) begin
      n = `ERR_JOY_PULSES;
    end
    if (f.battery_low) begin
      n = `ERR_BATT_PULSES;
    end
    if (f.onoff_active) begin
      n = `ERR_ONOFF_PULSES;
    end
    return n;
  endfunction

  flash_divider #(.HALF_CYC(FAST_HALF_CYC)) u_fast (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .clear_i   (1'b0),
    .tick_o    (),
    .phase_o   (fast_phase)
  );

  flash_divider #(.HALF_CYC(SLOW_HALF_CYC)) u_slow (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .clear_i   (1'b0),
    .tick_o    (),
    .phase_o   (slow_phase)
  );

  flash_divider #(.HALF_CYC(PULSE_HALF_CYC)) u_pulse (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .clear_i   (pulse_clear),
    .tick_o    (pulse_tick),
    .phase_o   (pulse_phase)
  );

  hold_timer #(.LIMIT_CYC(LEARN_HOLD_CYC)) u_learn (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .run_i     (state_reg == ST_LEARN && in_i.start),
    .done_o    (learn_done)
  );

  // the cycle in which done is raised still shows red, so the timer stops one short to keep red at exactly the limit
  hold_timer #(.LIMIT_CYC(DAMAGE_RED_CYC - 1)) u_damage (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .run_i     (state_reg == ST_DAMAGE),
    .done_o    (damage_done)
  );

  always_comb begin
    state_next    = state_reg;
    pulses_next   = pulses_reg;
    done_next     = done_reg;
    key_prev_next = in_i.key_pos1;
    if (in_i.damage && state_reg != ST_DAMAGE && state_reg != ST_LOCKED) begin
      state_next = ST_DAMAGE;
    end else begin
      case (state_reg)
        ST_OFF: begin
          if (key_rise) begin
            if (in_i.stop_pressed) begin
              state_next = ST_LEARN;
            end else if (activation_fault(in_i) != 3'h0) begin
              pulses_next = activation_fault(in_i);
              done_next   = 3'h0;
              state_next  = ST_ERROR;
            end else if (in_i.receiver_present) begin
              state_next = ST_WAIT_START;
            end
          end
        end
        ST_LEARN: begin
          if (!in_i.key_pos1) begin
            state_next = ST_OFF;
          end else if (!in_i.stop_pressed) begin
            // mushroom released at activation with learn pending: single red flash
            pulses_next = `ERR_STOP_PULSES;
            done_next   = 3'h0;
            state_next  = ST_ERROR;
          end else if (learn_done) begin
            state_next = ST_LOCKED;
          end
        end
        ST_WAIT_START: begin
          if (in_i.stop_pressed || !in_i.key_pos1) begin
            state_next = ST_OFF;
          end else if (in_i.start) begin
            state_next = ST_ON;
          end
        end
        ST_ON: begin
          if (in_i.stop_pressed || !in_i.key_pos1) begin
            state_next = ST_OFF;
          end
        end
        ST_ERROR: begin
          // a pulse counts as shown only when its red half ends; counting at the
          // start would blank the last pulse, and a single-pulse code would never light
          if (pulse_tick && pulse_phase) begin
            done_next = done_reg + 3'h1;
          end
          if (done_reg == pulses_reg) begin
            state_next = ST_LOCKED;
          end
        end
        ST_DAMAGE: begin
          if (damage_done) begin
            state_next = ST_LOCKED;
          end
        end
        ST_LOCKED: begin
          // dark until the key is returned to 0 with damage cleared; avoids replaying the error
          if (!in_i.key_pos1 && !in_i.damage) begin
            state_next = ST_OFF;
          end
        end
        default: begin
          state_next = ST_OFF;
        end
      endcase
    end
  end

  always_comb begin
    cmd_next    = '0;
    led_next    = remote_safety_pkg::LED_OFF;
    buzzer_next = 1'b0;
    case (state_reg)
      ST_LEARN: begin
        cmd_next.learn_code = learn_done;
        led_next = fast_phase ? remote_safety_pkg::LED_GREEN
                              : remote_safety_pkg::LED_OFF;
      end
      ST_WAIT_START: begin
        cmd_next.link_open = 1'b1;
        led_next = fast_phase ? remote_safety_pkg::LED_GREEN
                              : remote_safety_pkg::LED_OFF;
      end
      ST_ON: begin
        cmd_next.link_open               = 1'b1;
        cmd_next.system_on               = 1'b1;
        cmd_next.stop_cmd                = in_i.stop_pressed;
        cmd_next.unintended_motion_guard = in_i.joystick_off_zero;
        if (in_i.battery_low) begin
          led_next    = slow_phase ? remote_safety_pkg::LED_RED
                                   : remote_safety_pkg::LED_OFF;
          buzzer_next = slow_phase;
        end else begin
          led_next = slow_phase ? remote_safety_pkg::LED_GREEN
                                : remote_safety_pkg::LED_OFF;
        end
      end
      ST_ERROR: begin
        if (pulse_phase && done_reg < pulses_reg) begin
          led_next    = remote_safety_pkg::LED_RED;
          buzzer_next = 1'b1;
        end
      end
      ST_DAMAGE: begin
        led_next    = remote_safety_pkg::LED_RED;
        buzzer_next = 1'b1;
      end
      default: begin
        led_next = remote_safety_pkg::LED_OFF;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg    <= ST_OFF;
      pulses_reg   <= 3'h0;
      done_reg     <= 3'h0;
      key_prev_reg <= 1'b0;
      cmd_reg      <= '0;
      led_reg      <= remote_safety_pkg::LED_OFF;
      buzzer_reg   <= 1'b0;
    end else begin
      state_reg    <= state_next;
      pulses_reg   <= pulses_next;
      done_reg     <= done_next;
      key_prev_reg <= key_prev_next;
      cmd_reg      <= cmd_next;
      led_reg      <= led_next;
      buzzer_reg   <= buzzer_next;
    end
  end

  assign cmd_o    = cmd_reg;
  assign led_o    = led_reg;
  assign buzzer_o = buzzer_reg;
endmodule

// File: sim/remote_safety_checker.sv
// port assertions for the transmitter sequencer
module remote_safety_checker #(
  parameter int unsigned DAMAGE_RED_CYC = 20
) (
  input wire logic                           sys_clk_i,
  input wire logic                           arst_n_i,
  input wire remote_safety_pkg::tx_inputs_t   in_i,
  input wire remote_safety_pkg::tx_commands_t cmd_o,
  input wire remote_safety_pkg::led_color_t   led_o,
  input wire logic                           buzzer_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  logic        red;
  int unsigned run_reg;
  int unsigned run_next;
  assign red = (led_o == remote_safety_pkg::LED_RED);
  always_comb run_next = red ? run_reg + 1 : 0;
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i)
      run_reg <= 0;
    else
      run_reg <= run_next;
  end
  a_key_off_dark: assert property (!in_i.key_pos1 [*3] |-> !cmd_o.link_open && !cmd_o.system_on)
    else $error("link or system on with key at 0");
  a_stop_dark: assert property (in_i.stop_pressed [*3] |-> !cmd_o.system_on)
    else $error("system on with mushroom held");
  a_stop_sent: assert property (in_i.stop_pressed |=> cmd_o.stop_cmd || !cmd_o.system_on)
    else $error("stop command missing");
  a_guard_sent: assert property (in_i.joystick_off_zero |=> cmd_o.unintended_motion_guard || !cmd_o.system_on)
    else $error("safety command missing");
  a_buzz_red: assert property (red |-> buzzer_o)
    else $error("red lit without buzzer");
  a_learn_once: assert property (cmd_o.learn_code |=> !cmd_o.learn_code [*2])
    else $error("learn pulse too long");
  a_damage_red: assert property ($rose(in_i.damage) && cmd_o.system_on |-> ##2 red)
    else $error("damage not shown red");
  a_red_bound: assert property (run_reg <= DAMAGE_RED_CYC)
    else $error("red held too long");
  a_wait_green: assert property (cmd_o.link_open && !cmd_o.system_on |-> !red)
    else $error("red while waiting for start");
  a_link_fast: assert property ($rose(in_i.key_pos1) && !$past(in_i.key_pos1, 2) && in_i.receiver_present
    && (in_i & 8'h9e) == 8'h00 |-> ##2 cmd_o.link_open)
    else $error("link not opened at enable");
endmodule

// File: sim/receiver_model.sv
// behavioural paired receiver driving the stop circuit
module receiver_model (
  input  wire logic                            sys_clk_i,
  input  wire logic                            arst_n_i,
  input  wire remote_safety_pkg::tx_commands_t cmd_i,
  input  wire logic                            powered_i,
  input  wire logic                            link_ok_i,
  output logic                                 present_o,
  output logic                                 stop_closed_o
);
  assign present_o = powered_i;
  // opens in one cycle, well inside both reaction bounds
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i)
      stop_closed_o <= 1'b0;
    else
      stop_closed_o <= cmd_i.system_on && !cmd_i.stop_cmd && link_ok_i && powered_i;
  end
endmodule

// File: sim/tb_remote_safety_sequencer.sv
// self-checking bench of the transmitter sequencer
module tb_remote_safety_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  logic                            sys_clk_i;
  logic                            arst_n_i;
  logic                            powered;
  logic                            link_ok;
  logic                            present;
  logic                            stop_closed;
  logic                            buzzer_o;
  remote_safety_pkg::tx_inputs_t   tx_in;
  remote_safety_pkg::tx_inputs_t   in_w;
  remote_safety_pkg::tx_commands_t cmd_o;
  remote_safety_pkg::led_color_t   led_o;
  int miscompares, comparisons, red_cyc, red_rise, grn_rise, learn_cnt, buz_bad;
  logic [7:0] fault [3] = '{8'h50, 8'h44, 8'h48};
  assign in_w = {tx_in[7:1], present};
  remote_safety_sequencer #(.LEARN_HOLD_CYC(20), .DAMAGE_RED_CYC(20), .FAST_HALF_CYC(2),
    .SLOW_HALF_CYC(6), .PULSE_HALF_CYC(3)) dut (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
    .in_i(in_w), .cmd_o(cmd_o), .led_o(led_o), .buzzer_o(buzzer_o));
  receiver_model rx (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .cmd_i(cmd_o),
    .powered_i(powered), .link_ok_i(link_ok), .present_o(present), .stop_closed_o(stop_closed));
  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task automatic idle;
    tx_in = '0;
    cyc(6);
  endtask
  task automatic turn_on;
    idle();
    tx_in.key_pos1 = 1'b1;
    cyc(3);
    tx_in.start = 1'b1;
    cyc(3);
    tx_in.start = 1'b0;
  endtask
  // counts pattern edges at the falling edge, where outputs have settled
  task automatic watch(input int n);
    logic r;
    logic g;
    red_cyc = 0;
    red_rise = 0;
    grn_rise = 0;
    learn_cnt = 0;
    buz_bad = 0;
    r = (led_o === remote_safety_pkg::LED_RED);
    g = (led_o === remote_safety_pkg::LED_GREEN);
    repeat (n) begin
      @(negedge sys_clk_i);
      red_cyc += (led_o === remote_safety_pkg::LED_RED);
      red_rise += (led_o === remote_safety_pkg::LED_RED && !r);
      grn_rise += (led_o === remote_safety_pkg::LED_GREEN && !g);
      learn_cnt += (cmd_o.learn_code === 1'b1);
      buz_bad += (buzzer_o !== (led_o === remote_safety_pkg::LED_RED));
      r = (led_o === remote_safety_pkg::LED_RED);
      g = (led_o === remote_safety_pkg::LED_GREEN);
    end
  endtask
  task automatic conclude;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #(3000 * 50);
    miscompares++;
    conclude();
  end
  initial begin
    tx_in = '0;
    powered = 1'b0;
    link_ok = 1'b1;
    arst_n_i = 1'b0;
    cyc(8);
    arst_n_i = 1'b1;
    check("cmd_reset", cmd_o, 0);
    tx_in.key_pos1 = 1'b1;
    cyc(4);
    check("link_no_receiver", cmd_o.link_open, 0);
    powered = 1'b1;
    idle();
    tx_in.key_pos1 = 1'b1;
    cyc(3);
    check("link_open", cmd_o.link_open, 1);
    watch(24);
    check("fast_green", grn_rise, 6);
    tx_in.start = 1'b1;
    cyc(3);
    tx_in.start = 1'b0;
    check("system_on", cmd_o.system_on, 1);
    check("stop_closed", stop_closed, 1);
    watch(24);
    check("slow_green", grn_rise, 2);
    tx_in.joystick_off_zero = 1'b1;
    cyc(2);
    check("guard", cmd_o.unintended_motion_guard, 1);
    tx_in.joystick_off_zero = 1'b0;
    tx_in.battery_low = 1'b1;
    cyc(4);
    watch(24);
    check("low_batt_red", red_cyc, 12);
    check("batt_buzzer", buz_bad, 0);
    tx_in.battery_low = 1'b0;
    tx_in.stop_pressed = 1'b1;
    cyc(1);
    check("stop_cmd", cmd_o.stop_cmd, 1);
    cyc(3);
    check("off_by_stop", cmd_o.system_on, 0);
    check("stop_open", stop_closed, 0);
    turn_on();
    link_ok = 1'b0;
    cyc(2);
    check("link_loss_open", stop_closed, 0);
    link_ok = 1'b1;
    tx_in.key_pos1 = 1'b0;
    cyc(3);
    check("off_by_key", cmd_o, 0);
    turn_on();
    tx_in.damage = 1'b1;
    watch(40);
    check("damage_red", red_cyc, 20);
    check("damage_buzzer", buz_bad, 0);
    check("damage_dark", led_o, 0);
    idle();
    tx_in.stop_pressed = 1'b1;
    tx_in.key_pos1 = 1'b1;
    cyc(3);
    tx_in.stop_pressed = 1'b0;
    watch(30);
    check("err_stop", red_rise, 1);
    for (int i = 0; i < 3; i++) begin
      idle();
      tx_in = fault[i];
      watch(40);
      check("err_pulses", red_rise, i + 2);
      check("err_buzzer", buz_bad, 0);
      check("err_dark", led_o, 0);
    end
    idle();
    tx_in.stop_pressed = 1'b1;
    tx_in.key_pos1 = 1'b1;
    cyc(2);
    tx_in.start = 1'b1;
    watch(40);
    check("learn_pulse", learn_cnt, 1);
    watch(12);
    check("learn_no_blink", grn_rise, 0);
    idle();
    conclude();
  end
endmodule
bind remote_safety_sequencer remote_safety_checker #(.DAMAGE_RED_CYC(DAMAGE_RED_CYC)) chk (
  .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .in_i(in_i), .cmd_o(cmd_o), .led_o(led_o),
  .buzzer_o(buzzer_o));
